/* File: hdl/configurable_io_port.sv */
// Top: three bytewise I/O ports with data-space access and interrupt requests
`timescale 1ns/1ns
`default_nettype none
module configurable_io_port #(
   parameter int              WIDTH     = 8,
   parameter logic [7:0]      ANALOG_A  = 8'h30,
   parameter logic [7:0]      ANALOG_B  = 8'h00,
   parameter logic [7:0]      ANALOG_C  = 8'h0c
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   clk_en,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   input  wire logic [1:0]             port_idx,
   input  wire logic [1:0]             reg_idx,
   input  wire logic [WIDTH-1:0]       wr_data,
   output logic      [WIDTH-1:0]       rd_data,
   input  wire logic                   source1_level_select,
   input  wire logic                   source2_edge_select,
   input  wire logic                   global_irq_enable,
   input  wire logic [3*WIDTH-1:0]     pin_in,
   output logic      [3*WIDTH-1:0]     pin_out,
   output logic      [3*WIDTH-1:0]     pin_oe,
   output logic      [3*WIDTH-1:0]     pull_up_en,
   output logic      [3*WIDTH-1:0]     analog_sel,
   output logic                        source1_irq,
   output logic                        source2_irq
);
   import io_port_pkg::*;

   logic [3*WIDTH-1:0] out_c;
   logic [3*WIDTH-1:0] oe_c;
   logic [3*WIDTH-1:0] pu_c;
   logic [3*WIDTH-1:0] an_c;
   logic [WIDTH-1:0]   rd_c [PORT_COUNT];
   logic [2:0]         req_c;
   logic [3*WIDTH-1:0] analog_mask;
   trig_mode_t         mode_c [PORT_COUNT];

   // Decode register index into a select; unmapped index selects nothing
   function automatic reg_sel_t decode_sel(input logic [1:0] idx);
      reg_sel_t s;
      s = SEL_NONE;
      if (idx == REG_SEL_DATA) begin
         s = SEL_DATA;
      end else if (idx == REG_SEL_DIR) begin
         s = SEL_DIR;
      end else if (idx == REG_SEL_OPT) begin
         s = SEL_OPT;
      end
      return s;
   endfunction

   assign analog_mask = {ANALOG_C, ANALOG_B, ANALOG_A};

   // Ports A and B share source 1, port C uses source 2
   always_comb begin
      mode_c[0] = source1_level_select ? TRIG_LEVEL : TRIG_FALL;
      mode_c[1] = mode_c[0];
      mode_c[2] = source2_edge_select ? TRIG_RISE : TRIG_FALL;
   end

   // One slice per port; each gets its write strobe by port index
   for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
      io_line_slice #(
         .WIDTH(WIDTH)
      ) u_slice (
         .clk            (clk),
         .rst_b          (rst_b),
         .clk_en         (clk_en),
         .wr_en          (wr_en && (port_idx == 2'(p))),
         .wr_sel         (decode_sel(reg_idx)),
         .wr_data        (wr_data),
         .rd_sel         (decode_sel(reg_idx)),
         .rd_data        (rd_c[p]),
         .pin_in         (pin_in[p*WIDTH +: WIDTH]),
         .analog_capable (analog_mask[p*WIDTH +: WIDTH]),
         .trig_mode      (mode_c[p]),
         .pin_out        (out_c[p*WIDTH +: WIDTH]),
         .pin_oe         (oe_c[p*WIDTH +: WIDTH]),
         .pull_up_en     (pu_c[p*WIDTH +: WIDTH]),
         .analog_sel     (an_c[p*WIDTH +: WIDTH]),
         .irq_req        (req_c[p])
      );
   end

   // Registered pin side; one cycle after a register write
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_out    <= '0;
         pin_oe     <= '0;
         pull_up_en <= '1;       // Reset mode is pulled-up input
         analog_sel <= '0;
      end else if (clk_en) begin
         pin_out    <= out_c;
         pin_oe     <= oe_c;
         pull_up_en <= pu_c;
         analog_sel <= an_c;
      end
   end

   // Read data registered; out-of-range port or register reads zero
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rd_data <= '0;
      end else if (clk_en && rd_en) begin
         if (port_idx < 2'(PORT_COUNT)) begin
            rd_data <= rd_c[port_idx];
         end else begin
            rd_data <= '0;
         end
      end
   end

   // Requests gated by global enable; level so the controller samples it
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         source1_irq <= 1'b0;
         source2_irq <= 1'b0;
      end else if (clk_en) begin
         source1_irq <= global_irq_enable & (req_c[0] | req_c[1]);
         source2_irq <= global_irq_enable & req_c[2];
      end
   end
endmodule
`default_nettype wire

/* File: hdl/io_port_pkg.sv */
// Package: constants for the configurable I/O port block
package io_port_pkg;
   localparam int          PORT_WIDTH       = 8;
   localparam int          PORT_COUNT       = 3;
   localparam logic [7:0]  LATCH_RESET      = 8'h00;
   localparam logic [7:0]  DIR_RESET        = 8'h00;
   localparam logic [7:0]  OPT_RESET        = 8'h00;
   localparam logic [1:0]  REG_SEL_DATA     = 2'h0;
   localparam logic [1:0]  REG_SEL_DIR      = 2'h1;
   localparam logic [1:0]  REG_SEL_OPT      = 2'h2;
   // Which register of a port an access targets
   typedef enum logic [1:0] {
      SEL_DATA = 2'b00,
      SEL_DIR  = 2'b01,
      SEL_OPT  = 2'b10,
      SEL_NONE = 2'b11
   } reg_sel_t;
   // Trigger mode of a port request
   typedef enum logic [1:0] {
      TRIG_FALL  = 2'b00,
      TRIG_RISE  = 2'b01,
      TRIG_LEVEL = 2'b10,
      TRIG_OFF   = 2'b11
   } trig_mode_t;
endpackage

/* File: hdl/io_line_slice.sv */
// One port slice: three registers, pin drive and request detection
`timescale 1ns/1ns
`default_nettype none
module io_line_slice #(
   parameter int WIDTH = 8
) (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   clk_en,
   input  wire logic                   wr_en,
   input  wire io_port_pkg::reg_sel_t  wr_sel,
   input  wire logic [WIDTH-1:0]       wr_data,
   input  wire io_port_pkg::reg_sel_t  rd_sel,
   output logic      [WIDTH-1:0]       rd_data,
   input  wire logic [WIDTH-1:0]       pin_in,
   input  wire logic [WIDTH-1:0]       analog_capable,
   input  wire io_port_pkg::trig_mode_t trig_mode,
   output logic      [WIDTH-1:0]       pin_out,
   output logic      [WIDTH-1:0]       pin_oe,
   output logic      [WIDTH-1:0]       pull_up_en,
   output logic      [WIDTH-1:0]       analog_sel,
   output logic                        irq_req
);
   import io_port_pkg::*;

   logic [WIDTH-1:0] port_level_latch_q;
   logic [WIDTH-1:0] line_direction_reg_q;
   logic [WIDTH-1:0] line_option_reg_q;
   logic [WIDTH-1:0] pin_prev_q;
   logic [WIDTH-1:0] irq_lines;
   logic [WIDTH-1:0] data_view;

   // Register writes; reset clears all three so lines start as pulled-up inputs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         port_level_latch_q   <= LATCH_RESET;
         line_direction_reg_q <= DIR_RESET;
         line_option_reg_q    <= OPT_RESET;
      end else if (clk_en && wr_en) begin
         if (wr_sel == SEL_DATA) begin
            port_level_latch_q <= wr_data;
         end else if (wr_sel == SEL_DIR) begin
            line_direction_reg_q <= wr_data;
         end else if (wr_sel == SEL_OPT) begin
            line_option_reg_q <= wr_data;
         end
      end
   end

   // Previous pin level for edge detection
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pin_prev_q <= '1;
      end else if (clk_en) begin
         pin_prev_q <= pin_in;
      end
   end

   // Input lines read the pin; output lines read back the latch
   always_comb begin
      data_view = (line_direction_reg_q & port_level_latch_q)
                | (~line_direction_reg_q & pin_in);
      rd_data   = '0;
      case (rd_sel)
         SEL_DATA: rd_data = data_view;
         SEL_DIR:  rd_data = line_direction_reg_q;
         SEL_OPT:  rd_data = line_option_reg_q;
         default:  rd_data = '0;
      endcase
   end

   // Pin modes decoded per line from direction, option and latch
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         // Open drain drives only low; push-pull drives both levels
         pin_out[i] = port_level_latch_q[i];
         pin_oe[i]  = line_direction_reg_q[i]
                    & (line_option_reg_q[i] | ~port_level_latch_q[i]);
         // Pull-up only for inputs with latch cleared
         pull_up_en[i] = ~line_direction_reg_q[i] & ~port_level_latch_q[i];
         analog_sel[i] = ~line_direction_reg_q[i] & line_option_reg_q[i]
                       & port_level_latch_q[i] & analog_capable[i];
         irq_lines[i]  = ~line_direction_reg_q[i] & line_option_reg_q[i]
                       & ~port_level_latch_q[i];
      end
   end

   // Combine interrupt lines into one request per port
   always_comb begin
      case (trig_mode)
         TRIG_FALL:  irq_req = |(irq_lines & pin_prev_q & ~pin_in);
         TRIG_RISE:  irq_req = |(irq_lines & ~pin_prev_q & pin_in);
         TRIG_LEVEL: irq_req = |(irq_lines & ~pin_in);
         default:    irq_req = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

/* File: test/configurable_io_port_properties.sv */
// Checker: port properties of the configurable I/O port
`timescale 1ns/1ns
`default_nettype none
module configurable_io_port_properties #(parameter int WIDTH = 8) (
   input wire logic               clk, rst_b, clk_en, wr_en, rd_en,
   input wire logic               source1_level_select, source2_edge_select, global_irq_enable,
   input wire logic               source1_irq, source2_irq,
   input wire logic [1:0]         port_idx, reg_idx,
   input wire logic [WIDTH-1:0]   wr_data, rd_data,
   input wire logic [3*WIDTH-1:0] pin_in, pin_out, pin_oe, pull_up_en, analog_sel
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // Reset leaves every line a pulled-up input
   a_reset_state: assert property ($rose(rst_b) |-> pull_up_en == '1 && pin_oe == '0 && rd_data == '0)
      else $error("outputs not cleared by reset");
   // Pull-up only on undriven, non-analog lines
   a_analog_no_pull: assert property ((analog_sel & pull_up_en) == '0)
      else $error("pull-up on analog line");
   a_drive_no_pull: assert property ((pin_oe & pull_up_en) == '0)
      else $error("pull-up on driven line");
   a_irq_gated: assert property (clk_en && !global_irq_enable |=> !source1_irq && !source2_irq)
      else $error("request with global enable low");
   a_unmapped_zero: assert property (clk_en && rd_en && (port_idx == 2'h3 || reg_idx == 2'h3) |=> rd_data == '0)
      else $error("unmapped read not zero");
   a_read_holds: assert property (!(clk_en && rd_en) |=> $stable(rd_data))
      else $error("read data moved without a read");
   a_freeze_holds: assert property (!clk_en |=> $stable(pin_out) && $stable(pin_oe))
      else $error("pins moved while frozen");
   // Latch write reaches the port A pins two edges later
   a_latch_drives: assert property ((clk_en && wr_en && port_idx == 2'h0 && reg_idx == 2'h0) ##1 clk_en
      |=> pin_out[WIDTH-1:0] == $past(wr_data, 2))
      else $error("latch value not on pins");
endmodule
bind configurable_io_port configurable_io_port_properties #(.WIDTH(WIDTH)) configurable_io_port_properties_inst (
   .clk, .rst_b, .clk_en,
   .wr_en, .rd_en, .source1_level_select, .source2_edge_select, .global_irq_enable, .source1_irq, .source2_irq,
   .port_idx, .reg_idx, .wr_data, .rd_data, .pin_in, .pin_out, .pin_oe, .pull_up_en, .analog_sel);
`default_nettype wire

/* File: test/pin_model.sv */
// Partner: pads with outside drivers, pull-ups and floating lines
`timescale 1ns/1ns
`default_nettype none
module pin_model (
   input  wire logic        clk,
   input  wire logic [23:0] pin_out, pin_oe, pull_up_en, ext_drv, ext_en,
   output logic      [23:0] pin_lvl
);
   logic [23:0] flt_q = 24'h5a5a5a;
   // A floating pad wanders, so no stale level passes for a read
   always @(posedge clk) flt_q <= ~flt_q;
   // Port drive wins, then the outside world, then the pull-up
   assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_drv)
      | (~pin_oe & ~ext_en & (pull_up_en | flt_q));
endmodule
`default_nettype wire

/* File: test/configurable_io_port_tb.sv */
// Testbench: register access, line modes and port requests
`timescale 1ns/1ns
`default_nettype none
module configurable_io_port_tb;
   import io_port_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
   logic        source1_level_select = 1'b0, source2_edge_select = 1'b0, global_irq_enable = 1'b0;
   logic        source1_irq, source2_irq;
   logic [1:0]  port_idx = 2'h0, reg_idx = 2'h0;
   logic [7:0]  wr_data = 8'h00, rd_data, d, o, l, r;
   logic [23:0] pin_in, pin_out, pin_oe, pull_up_en, analog_sel, ext_drv = 24'hffffff, ext_en = 24'h0;
   logic [7:0]  exp_q[$];
   logic [34:0] stp [9] = '{{3'h1, 24'hfffffe, 8'h10}, {3'h1, 24'hffffff, 8'h00}, {3'h1, 24'hfffffd, 8'h00},
      {3'h1, 24'hffffff, 8'h00}, {3'h4, 24'hfffffe, 8'h00}, {3'h5, 24'hfffffe, 8'h80},
      {3'h3, 24'hfefffe, 8'h00}, {3'h3, 24'hfffffe, 8'h01}, {3'h1, 24'hfefffe, 8'h01}};
   int          mismatches = 0, checks = 0, n1, n2;
   configurable_io_port configurable_io_port_inst (.clk, .rst_b, .clk_en, .wr_en, .rd_en, .port_idx, .reg_idx,
      .wr_data, .rd_data, .source1_level_select, .source2_edge_select, .global_irq_enable, .pin_in, .pin_out,
      .pin_oe, .pull_up_en, .analog_sel, .source1_irq, .source2_irq);
   pin_model pin_model_inst (.clk, .pin_out, .pin_oe, .pull_up_en, .ext_drv, .ext_en, .pin_lvl(pin_in));
   // 125 MHz clock
   initial forever #4 clk = ~clk;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      if (mismatches == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // One access; a read notes its expected byte for the monitor
   task automatic acc(input logic w, input logic [1:0] p, input logic [1:0] g, input logic [7:0] v);
      @(posedge clk);
      #2;
      {wr_en, rd_en, port_idx, reg_idx, wr_data} = {w, !w, p, g, v};
      if (!w) exp_q.push_back(v);
      @(posedge clk);
      #2;
      {wr_en, rd_en} = 2'b00;
   endtask
   // Drive the pads, then count request cycles over eight edges
   task automatic cnt(input logic [23:0] v);
      @(posedge clk);
      #2;
      ext_drv = v;
      {n1, n2} = {32'd0, 32'd0};
      repeat (8) begin
         @(posedge clk);
         #1;
         n1 += int'(source1_irq === 1'b1);
         n2 += int'(source2_irq === 1'b1);
      end
      #1;
   endtask
   // Monitor: read data settles on the same edge that takes the read
   initial forever begin
      @(posedge clk);
      #1;
      if (rd_en && clk_en && rst_b) chk(rd_data, exp_q.pop_front());
   end
   // Main sequence
   initial begin
      void'($urandom(76));
      repeat (8) @(posedge clk);
      #2;
      rst_b = 1'b1;
      for (int i = 0; i < 9; i++) acc(1'b0, 2'(i % 3), 2'(i / 3), (i < 3) ? 8'hff : 8'h00);
      chk(pull_up_en[7:0], 8'hff);
      // Frozen write, unmapped places, then random bytes kept like RAM
      clk_en = 1'b0;
      acc(1'b1, 2'h0, 2'h1, 8'hff);
      clk_en = 1'b1;
      acc(1'b0, 2'h0, 2'h1, 8'h00);
      acc(1'b1, 2'h3, 2'h1, 8'hff);
      acc(1'b0, 2'h3, 2'h1, 8'h00);
      acc(1'b0, 2'h1, 2'h3, 8'h00);
      for (int i = 0; i < 6; i++) begin
         r = 8'($urandom);
         acc(1'b1, 2'(i % 3), 2'(1 + i / 3), r);
         acc(1'b0, 2'(i % 3), 2'(1 + i / 3), r);
         // Latches still clear, so every direction bit set is a line pulling low
         if (i < 3) chk(pin_oe[8*i +: 8], r);
      end
      // All eight modes on port A; write order keeps one analog line at most
      ext_en = 24'h0000ff;
      for (int m = 0; m < 8; m++) begin
         r = 8'($urandom);
         ext_drv = {16'hffff, r};
         {d, o, l} = {{8{m[2]}}, {8{m[1]}}, (m == 3) ? 8'h10 : {8{m[0]}}};
         acc(1'b1, 2'h0, 2'h1, d);
         acc(1'b1, 2'h0, 2'h0, l);
         acc(1'b1, 2'h0, 2'h2, o);
         acc(1'b0, 2'h0, 2'h0, (d & l) | (~d & r));
         chk(pin_out[7:0], l);
         chk(pin_oe[7:0], d & (o | ~l));
         chk(pull_up_en[7:0], ~d & ~l);
         chk(analog_sel[7:0], ~d & o & l & 8'h30);
      end
      // Line 0 of ports A and C becomes a pulled-up request input
      {ext_en, ext_drv} = {24'hffffff, 24'hffffff};
      for (int p = 0; p < 3; p += 2) begin
         acc(1'b1, 2'(p), 2'h0, 8'h00);
         acc(1'b1, 2'(p), 2'h2, 8'h01);
         acc(1'b1, 2'(p), 2'h1, 8'h00);
      end
      foreach (stp[k]) begin
         {source1_level_select, source2_edge_select, global_irq_enable} = stp[k][34:32];
         cnt(stp[k][31:8]);
         chk(8'(n1), {4'h0, stp[k][7:4]});
         chk(8'(n2), {4'h0, stp[k][3:0]});
      end
      // Port C line 2 goes analog; option first so only one line is ever analog
      acc(1'b1, 2'h2, 2'h2, 8'h05);
      acc(1'b1, 2'h2, 2'h0, 8'h0c);
      acc(1'b0, 2'h2, 2'h2, 8'h05);
      chk(analog_sel[23:16], 8'h04);
      chk(pull_up_en[23:16], 8'hf3);
      finish_test();
   end
   // Hang guard
   initial begin
      #500000;
      mismatches++;
      finish_test();
   end
endmodule
`default_nettype wire
